/* File: core/gpab_regs.svh */
`ifndef GPAB_REGS_SVH
`define GPAB_REGS_SVH
// register indices (byte address = 4 * index)
`define GPAB_IDX_A_DATA   8'h00
`define GPAB_IDX_B_DATA   8'h01
`define GPAB_IDX_A_DIR    8'h04
`define GPAB_IDX_B_DIR    8'h05
`define GPAB_IDX_B_DRIVE  8'h0C
`define GPAB_IDX_PERIPH   8'h10
`define GPAB_IDX_ADC_SEL  8'h11
`define GPAB_IDX_A_PIN    8'h12
`define GPAB_IDX_B_PIN    8'h13
// drive strength register fields
`define GPAB_HD_LO        2
`define GPAB_HD_HI        5
`define GPAB_CKS_LO       0
`define GPAB_CKS_HI       1
`define GPAB_PEND_BIT     7
`define GPAB_CKS_EXT      2'h1
// peripheral enable register fields
`define GPAB_PE_KBD_LO    0
`define GPAB_PE_KBD_HI    3
`define GPAB_PE_LCD       4
// reset values
`define GPAB_DIR_RST      8'h00
`define GPAB_DRV_RST      8'h00
`define GPAB_ADC_RST      5'h1F
`endif

/* File: core/gpab_pkg.sv */
package gpab_pkg;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gpab_wb_req_s;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [3:0] hd;
  } gpab_pad_b_s;

  typedef struct packed {
    logic [1:0] t1_els0;
    logic [1:0] t1_els1;
    logic [1:0] t2_els0;
    logic [1:0] t2_els1;
  } gpab_timer_cfg_s;
endpackage

/* File: core/gpab_pin_mux.sv */
`timescale 1ns/100ps
// one pad: peripheral owner wins over port direction and latch
module gpab_pin_mux (
  // port side
  input  wire logic port_dir_i,
  input  wire logic port_dat_i,
  // peripheral side
  input  wire logic own_i,
  input  wire logic own_oe_i,
  input  wire logic own_dat_i,
  // pad
  output logic      pad_o,
  output logic      pad_oe_o
);
  always_comb begin
    if (own_i) begin
      pad_oe_o = own_oe_i;
      pad_o    = own_dat_i;
    end else begin
      pad_oe_o = port_dir_i;
      pad_o    = port_dat_i;
    end
  end
endmodule

/* File: core/gpab_top.sv */
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "gpab_regs.svh"
module gpab_top (
  // system
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone slave
  input  wire gpab_pkg::gpab_wb_req_s wb_req_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // port A pads
  input  wire logic [7:0]             pa_i,
  output logic [7:0]                  pa_o,
  output logic [7:0]                  pa_oe_o,
  // port B pads
  input  wire logic [7:0]             pb_i,
  output gpab_pkg::gpab_pad_b_s       pb_pad_o,
  // timer and display pin functions
  input  wire gpab_pkg::gpab_timer_cfg_s tmr_cfg_i,
  input  wire logic [3:0]             tmr_oe_i,
  input  wire logic [3:0]             tmr_dat_i,
  input  wire logic [1:0]             fp_dat_i,
  input  wire logic                   periodic_irq_pending_latch_i,
  // pin function outputs
  output logic [3:0]                  keypad_wake_input_o,
  output logic [3:0]                  tmr_in_o,
  output logic                        periodic_irq_ext_clock_pin_o,
  output logic                        periodic_irq_ext_sel_o,
  output logic [5:0]                  converter_pin_sel_o,
  output logic                        display_driver_enable_o
);
  import gpab_pkg::*;

  typedef struct packed {
    logic [7:0] a_dat;
    logic [7:0] b_dat;
    logic [7:0] a_dir;
    logic [7:0] b_dir;
    logic [5:0] b_drv;
    logic [4:0] kbd_lcd;
    logic [4:0] adc_sel;
    logic       ack;
    logic [7:0] rdat;
  } gpab_state_s;

  gpab_state_s st_q;
  gpab_state_s st_d;

  // byte lane 0 holds every register
  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] d, input logic s);
    wr8 = s ? d[7:0] : old;
  endfunction

  // input pins read the pad, output pins read the latch
  function automatic logic [7:0] port_rd(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
    port_rd = (dir & lat) | (~dir & pin);
  endfunction

  // converter channels 0..5 map to A4..A7, B0, B1
  function automatic logic [5:0] adc_dec(input logic [4:0] ch);
    adc_dec = 6'h00;
    if (ch < 5'h06) begin
      adc_dec[ch[2:0]] = 1'b1;
    end
  endfunction

  logic       req;
  logic       wr;
  logic [7:0] rd_mux;
  logic [5:0] adc_own;
  logic [7:0] a_own;
  logic [7:0] a_own_oe;
  logic [7:0] b_own;
  logic [7:0] b_own_oe;
  logic [7:0] b_own_dat;
  logic [3:0] tmr_own;

  assign req = wb_req_i.cyc & wb_req_i.stb & ~st_q.ack;
  assign wr  = req & wb_req_i.we;

  always_comb begin
    case (wb_req_i.adr)
      `GPAB_IDX_A_DATA:  rd_mux = port_rd(st_q.a_dir, st_q.a_dat, pa_i);
      `GPAB_IDX_B_DATA:  rd_mux = port_rd(st_q.b_dir, st_q.b_dat, pb_i);
      `GPAB_IDX_A_DIR:   rd_mux = st_q.a_dir;
      `GPAB_IDX_B_DIR:   rd_mux = st_q.b_dir;
      `GPAB_IDX_B_DRIVE: rd_mux = {periodic_irq_pending_latch_i, 1'b0, st_q.b_drv};
      `GPAB_IDX_PERIPH:  rd_mux = {3'h0, st_q.kbd_lcd};
      `GPAB_IDX_ADC_SEL: rd_mux = {3'h0, st_q.adc_sel};
      `GPAB_IDX_A_PIN:   rd_mux = pa_i;
      `GPAB_IDX_B_PIN:   rd_mux = pb_i;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_d      = st_q;
    st_d.ack  = req;
    st_d.rdat = req ? rd_mux : st_q.rdat;
    if (wr) begin
      case (wb_req_i.adr)
        `GPAB_IDX_A_DATA:  st_d.a_dat = wr8(st_q.a_dat, wb_req_i.dat, wb_req_i.sel[0]);
        `GPAB_IDX_B_DATA:  st_d.b_dat = wr8(st_q.b_dat, wb_req_i.dat, wb_req_i.sel[0]);
        `GPAB_IDX_A_DIR:   st_d.a_dir = wr8(st_q.a_dir, wb_req_i.dat, wb_req_i.sel[0]);
        `GPAB_IDX_B_DIR:   st_d.b_dir = wr8(st_q.b_dir, wb_req_i.dat, wb_req_i.sel[0]);
        `GPAB_IDX_B_DRIVE: st_d.b_drv = wb_req_i.sel[0] ? wb_req_i.dat[5:0] : st_q.b_drv;
        `GPAB_IDX_PERIPH:  st_d.kbd_lcd = wb_req_i.sel[0] ? wb_req_i.dat[4:0] : st_q.kbd_lcd;
        `GPAB_IDX_ADC_SEL: st_d.adc_sel = wb_req_i.sel[0] ? wb_req_i.dat[4:0] : st_q.adc_sel;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // data latches keep their contents across reset
      st_q.a_dat   <= st_d.a_dat;
      st_q.b_dat   <= st_d.b_dat;
      st_q.a_dir   <= `GPAB_DIR_RST;
      st_q.b_dir   <= `GPAB_DIR_RST;
      st_q.b_drv   <= 6'(`GPAB_DRV_RST);
      st_q.kbd_lcd <= 5'h00;
      st_q.adc_sel <= `GPAB_ADC_RST;
      st_q.ack     <= 1'b0;
      st_q.rdat    <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = {24'h000000, st_q.rdat};

  // pin ownership
  assign adc_own = adc_dec(st_q.adc_sel);
  // keypad pins are inputs; converter pins float
  assign a_own    = {adc_own[3:0], st_q.kbd_lcd[`GPAB_PE_KBD_HI:`GPAB_PE_KBD_LO]};
  assign a_own_oe = 8'h00;
  assign tmr_own  = {|tmr_cfg_i.t2_els1, |tmr_cfg_i.t2_els0,
                     |tmr_cfg_i.t1_els1, |tmr_cfg_i.t1_els0};
  assign b_own     = {{2{st_q.kbd_lcd[`GPAB_PE_LCD]}}, tmr_own, adc_own[5:4]};
  assign b_own_oe  = {{2{st_q.kbd_lcd[`GPAB_PE_LCD]}}, tmr_oe_i, 2'b00};
  assign b_own_dat = {fp_dat_i, tmr_dat_i, 2'b00};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pad
      gpab_pin_mux u_a (
        .port_dir_i (st_q.a_dir[gi]),
        .port_dat_i (st_q.a_dat[gi]),
        .own_i      (a_own[gi]),
        .own_oe_i   (a_own_oe[gi]),
        .own_dat_i  (1'b0),
        .pad_o      (pa_o[gi]),
        .pad_oe_o   (pa_oe_o[gi])
      );
      gpab_pin_mux u_b (
        .port_dir_i (st_q.b_dir[gi]),
        .port_dat_i (st_q.b_dat[gi]),
        .own_i      (b_own[gi]),
        .own_oe_i   (b_own_oe[gi]),
        .own_dat_i  (b_own_dat[gi]),
        .pad_o      (pb_pad_o.o[gi]),
        .pad_oe_o   (pb_pad_o.oe[gi])
      );
    end
  endgenerate

  // high sink drive only while the port drives the pin as an output
  assign pb_pad_o.hd = st_q.b_drv[`GPAB_HD_HI:`GPAB_HD_LO] & st_q.b_dir[5:2] & ~b_own[5:2];

  assign keypad_wake_input_o = pa_i[3:0] & st_q.kbd_lcd[`GPAB_PE_KBD_HI:`GPAB_PE_KBD_LO];
  assign tmr_in_o            = pb_i[5:2] & tmr_own;
  assign periodic_irq_ext_sel_o =
    (st_q.b_drv[`GPAB_CKS_HI:`GPAB_CKS_LO] == `GPAB_CKS_EXT);
  assign periodic_irq_ext_clock_pin_o = periodic_irq_ext_sel_o & pb_i[2];
  assign converter_pin_sel_o     = adc_own;
  assign display_driver_enable_o = st_q.kbd_lcd[`GPAB_PE_LCD];

  // register bus and reset
  a_dir_reset: assert property (@(posedge clk_i)
    rst_i |=> st_q.a_dir == 8'h00 && st_q.b_dir == 8'h00)
    else $error("direction not cleared by reset");

  a_conv_reset: assert property (@(posedge clk_i)
    rst_i |=> converter_pin_sel_o == 6'h00 && !display_driver_enable_o && pb_pad_o.hd == 4'h0)
    else $error("pin functions not released by reset");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_ack_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("ack without request");

  a_rdat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> $stable(wb_dat_o))
    else $error("read data moved without request");

  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_req_i.we && wb_req_i.adr > `GPAB_IDX_B_PIN |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  a_sel_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && !wb_req_i.sel[0] |=> $stable(st_q.a_dir) && $stable(st_q.b_dir) && $stable(st_q.adc_sel))
    else $error("write landed without lane select");

  a_dir_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_req_i.adr == `GPAB_IDX_A_DIR && wb_req_i.sel[0] |=> st_q.a_dir == $past(wb_req_i.dat[7:0]))
    else $error("direction write lost");

  a_dir_b_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_req_i.adr == `GPAB_IDX_B_DIR && wb_req_i.sel[0] |=> st_q.b_dir == $past(wb_req_i.dat[7:0]))
    else $error("port B direction write lost");

  a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_req_i.adr == `GPAB_IDX_B_DATA && wb_req_i.sel[0] |=> st_q.b_dat == $past(wb_req_i.dat[7:0]))
    else $error("latch write lost");

  a_latch_a_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_req_i.adr == `GPAB_IDX_A_DATA && wb_req_i.sel[0] |=> st_q.a_dat == $past(wb_req_i.dat[7:0]))
    else $error("port A latch write lost");

  a_a_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_req_i.we && wb_req_i.adr == `GPAB_IDX_A_DATA
    |=> wb_dat_o[7:0] == (($past(st_q.a_dir) & $past(st_q.a_dat)) | (~$past(st_q.a_dir) & $past(pa_i))))
    else $error("port A read wrong");

  a_b_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_req_i.we && wb_req_i.adr == `GPAB_IDX_B_DATA
    |=> wb_dat_o[7:0] == (($past(st_q.b_dir) & $past(st_q.b_dat)) | (~$past(st_q.b_dir) & $past(pb_i))))
    else $error("port B read wrong");

  // pads and pin functions
  a_pad_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (pa_oe_o & ~a_own) == (st_q.a_dir & ~a_own))
    else $error("port A drive mismatch");

  a_b_pad_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (pb_pad_o.oe & ~b_own) == (st_q.b_dir & ~b_own))
    else $error("port B drive mismatch");

  a_kbd_float: assert property (@(posedge clk_i) disable iff (rst_i)
    (pa_oe_o[3:0] & st_q.kbd_lcd[3:0]) == 4'h0)
    else $error("keypad pin driven");

  a_kbd_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (keypad_wake_input_o & ~st_q.kbd_lcd[3:0]) == 4'h0)
    else $error("keypad input on disabled pin");

  a_adc_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(converter_pin_sel_o))
    else $error("several converter pins selected");

  a_adc_float: assert property (@(posedge clk_i) disable iff (rst_i)
    (pa_oe_o[7:4] & converter_pin_sel_o[3:0]) == 4'h0 && (pb_pad_o.oe[1:0] & converter_pin_sel_o[5:4]) == 2'h0)
    else $error("converter pin driven");

  a_adc_none: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.adc_sel > 5'h05 |-> converter_pin_sel_o == 6'h00)
    else $error("converter pin taken by unused code");

  a_adc_digital: assert property (@(posedge clk_i) disable iff (rst_i)
    pa_oe_o[7:4] == (st_q.a_dir[7:4] & ~converter_pin_sel_o[3:0]))
    else $error("port A analog pin not digital");

  a_adc_b_digital: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_pad_o.oe[1:0] == (st_q.b_dir[1:0] & ~converter_pin_sel_o[5:4]))
    else $error("port B analog pin not digital");

  a_tmr1_ch0: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_pad_o.oe[2] == ((tmr_cfg_i.t1_els0 != 2'h0) ? tmr_oe_i[0] : st_q.b_dir[2]))
    else $error("first timer channel 0 pin wrong");

  a_tmr1_ch1: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_pad_o.oe[3] == ((tmr_cfg_i.t1_els1 != 2'h0) ? tmr_oe_i[1] : st_q.b_dir[3]))
    else $error("first timer channel 1 pin wrong");

  a_tmr2_ch0: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_pad_o.oe[4] == ((tmr_cfg_i.t2_els0 != 2'h0) ? tmr_oe_i[2] : st_q.b_dir[4]))
    else $error("second timer channel 0 pin wrong");

  a_tmr2_ch1: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_pad_o.oe[5] == ((tmr_cfg_i.t2_els1 != 2'h0) ? tmr_oe_i[3] : st_q.b_dir[5]))
    else $error("second timer channel 1 pin wrong");

  a_tmr_in: assert property (@(posedge clk_i) disable iff (rst_i)
    (tmr_in_o & ~tmr_own) == 4'h0)
    else $error("timer input on port pin");

  a_own_data: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_cfg_i.t1_els0 != 2'h0 |-> pb_pad_o.o[2] == tmr_dat_i[0])
    else $error("owner data lost on pad");

  a_lcd_own: assert property (@(posedge clk_i) disable iff (rst_i)
    display_driver_enable_o |-> pb_pad_o.oe[7:6] == 2'b11 && pb_pad_o.o[7:6] == fp_dat_i)
    else $error("display pins not owned");

  a_lcd_free: assert property (@(posedge clk_i) disable iff (rst_i)
    !display_driver_enable_o |-> pb_pad_o.oe[7:6] == st_q.b_dir[7:6])
    else $error("display pins not released");

  a_hd_output: assert property (@(posedge clk_i) disable iff (rst_i)
    (pb_pad_o.hd & ~pb_pad_o.oe[5:2]) == 4'h0)
    else $error("high drive on input");

  a_hd_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (pb_pad_o.hd & ~st_q.b_drv[5:2]) == 4'h0)
    else $error("high drive without enable");

  a_ext_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    periodic_irq_ext_clock_pin_o |-> pb_i[2] && st_q.b_drv[1:0] == 2'h1)
    else $error("external clock misrouted");

  a_ext_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.b_drv[1:0] != 2'h1 |-> !periodic_irq_ext_clock_pin_o && !periodic_irq_ext_sel_o)
    else $error("external clock without select");
endmodule

/* File: verification/gpab_pins.sv */
`timescale 1ns/100ps
// pads seen from outside: a driven pad shows its own data, a floating one the outside source
module gpab_pins (
  // device pads
  input  wire logic [7:0]           pa_o_i,
  input  wire logic [7:0]           pa_oe_i,
  input  wire gpab_pkg::gpab_pad_b_s pb_pad_i,
  // outside sources
  input  wire logic [7:0]           ext_a_i,
  input  wire logic [7:0]           ext_b_i,
  // resolved pin levels
  output logic [7:0]                pa_o,
  output logic [7:0]                pb_o
);
  import gpab_pkg::*;
  assign pa_o = (pa_oe_i & pa_o_i) | (~pa_oe_i & ext_a_i);
  assign pb_o = (pb_pad_i.oe & pb_pad_i.o) | (~pb_pad_i.oe & ext_b_i);
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import gpab_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  gpab_wb_req_s    wb_req = '0;
  gpab_timer_cfg_s tcfg = '0;
  gpab_pad_b_s     pb_pad_o;
  logic [31:0]     wb_dat_o;
  logic            wb_ack_o, eck, esel, dde, pend = 1'b0;
  logic [7:0]      pa_i, pb_i, pa_o, pa_oe_o, ext_a = 8'h3C, ext_b = 8'hC3;
  logic [3:0]      toe = '0, tdat = '0, kwi, tin, t;
  logic [3:0]      sl = 4'h1;
  logic [1:0]      fp = '0;
  logic [5:0]      csel, oh;
  logic [7:0]      da, db, ra, rb, p, hdr, rd, eoa, eob, ebo, pna, pnb, tm, lm;
  int              errors = 0;
  int              comparisons = 0;

  always #5 clk_i = ~clk_i;

  gpab_top i_gpab_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pa_i(pa_i), .pa_o(pa_o), .pa_oe_o(pa_oe_o), .pb_i(pb_i),
    .pb_pad_o(pb_pad_o), .tmr_cfg_i(tcfg), .tmr_oe_i(toe), .tmr_dat_i(tdat), .fp_dat_i(fp),
    .periodic_irq_pending_latch_i(pend), .keypad_wake_input_o(kwi), .tmr_in_o(tin),
    .periodic_irq_ext_clock_pin_o(eck), .periodic_irq_ext_sel_o(esel),
    .converter_pin_sel_o(csel), .display_driver_enable_o(dde));

  gpab_pins i_gpab_pins (.pa_o_i(pa_o), .pa_oe_i(pa_oe_o), .pb_pad_i(pb_pad_o),
    .ext_a_i(ext_a), .ext_b_i(ext_b), .pa_o(pa_i), .pb_o(pb_i));

  task stop_test;
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // per bit: select one picks a, zero picks b
  function automatic logic [7:0] mix(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
    mix = (s & a) | (~s & b);
  endfunction

  // one classic cycle, held until ack is sampled, then released for a cycle
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, a, sl, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("ack", 8'h01, {7'h0, wb_ack_o});
    chk("dat_hi", 8'h00, {7'h0, |wb_dat_o[31:8]});
    rd = wb_dat_o[7:0];
    wb_req <= '0;
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, e, rd);
  endtask

  initial begin
    #100us;
    errors++;
    stop_test;
  end

  initial begin
    void'($urandom(3967));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("dir_a", 8'h04, 8'h00);
    rdc("dir_b", 8'h05, 8'h00);
    rdc("conv_sel", 8'h11, 8'h1F);
    chk("pa_oe", 8'h00, pa_oe_o);
    wb(1'b1, 8'h00, 8'hA5);
    rdc("dat_a_in", 8'h00, 8'h3C);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h04, 8'hFF);
    rdc("dat_a_kept", 8'h00, 8'hA5);
    wb(1'b1, 8'h20, 8'hFF);
    rdc("unmapped", 8'h20, 8'h00);
    sl = 4'h0;
    wb(1'b1, 8'h04, 8'h00);
    sl = 4'h1;
    rdc("sel_off", 8'h04, 8'hFF);
    for (int i = 0; i < 24; i++) begin
      da = 8'($urandom);
      wb(1'b1, 8'h00, da);
      {ext_a, ext_b, toe, tdat, fp, pend} <= 27'($urandom);
      tcfg <= 8'($urandom);
      db = 8'($urandom);
      ra = 8'($urandom);
      rb = 8'($urandom);
      p = 8'($urandom) & 8'h1F;
      hdr = (8'($urandom) & 8'h3C) | {6'h00, i[1:0]};
      oh = (i % 8 < 6) ? 6'h01 << (i % 8) : 6'h00;
      ra = ra & ~{oh[3:0], 4'h0};
      rb = rb & ~{6'h00, oh[5:4]};
      wb(1'b1, 8'h01, db);
      wb(1'b1, 8'h04, ra);
      wb(1'b1, 8'h05, rb);
      wb(1'b1, 8'h0C, hdr);
      wb(1'b1, 8'h10, p);
      wb(1'b1, 8'h11, 8'(i % 8));
      t = {|tcfg.t2_els1, |tcfg.t2_els0, |tcfg.t1_els1, |tcfg.t1_els0};
      tm = {2'h0, t, 2'h0};
      lm = {p[4], p[4], 6'h00};
      eoa = ra & ~{oh[3:0], p[3:0]};
      pna = mix(eoa, da, ext_a);
      eob = (rb & ~tm & ~lm & ~{6'h00, oh[5:4]}) | (tm & {2'h0, toe, 2'h0}) | lm;
      ebo = (db & ~tm & ~lm) | (tm & {2'h0, tdat, 2'h0}) | (lm & {fp, 6'h00});
      pnb = mix(eob, ebo, ext_b);
      rdc("dir_a", 8'h04, ra);
      rdc("dir_b", 8'h05, rb);
      rdc("drive", 8'h0C, {pend, 1'b0, hdr[5:0]});
      rdc("conv_sel", 8'h11, 8'(i % 8));
      rdc("dat_a", 8'h00, mix(ra, da, pna));
      rdc("dat_b", 8'h01, mix(rb, db, pnb));
      rdc("periph", 8'h10, p);
      rdc("pin_a", 8'h12, pna);
      rdc("pin_b", 8'h13, pnb);
      @(negedge clk_i);
      chk("pa_oe", eoa, pa_oe_o);
      chk("pa_o", eoa & da, pa_o & eoa);
      chk("pb_oe", eob, pb_pad_o.oe);
      chk("pb_o", eob & ebo, pb_pad_o.o & eob);
      chk("pb_hd", hdr[5:2] & rb[5:2] & ~t, pb_pad_o.hd);
      chk("keypad", pna[3:0] & p[3:0], kwi);
      chk("tmr_in", pnb[5:2] & t, tin);
      chk("ext_sel", hdr[1:0] == 2'h1, esel);
      chk("ext_clk", (hdr[1:0] == 2'h1) & pnb[2], eck);
      chk("conv_pin", oh, csel);
      chk("display", p[4], dde);
    end
    stop_test;
  end
endmodule
